// *** timer_ops_pkg.sv ***
// Purpose: shared constants for the timer operator set
// Assumes: ref_clk at 25 MHz
// Notes: times kept in their own unit, cycle counts derived
package timer_ops_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int TIME_W = 14;
    localparam int TV_W = 17;
    localparam int CYC_W = 18;
    localparam int DUTY_W = 21;

    // ------------------------------------------------------------
    // time bases
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int STEP_FINE_MS = 10;
    localparam int STEP_COARSE_MS = 100;
    localparam int STEP_HALF_S_MS = 500;
    localparam int STEP_LONG_MS = 5000;
    localparam int NS_PER_MS = 1000000;
    localparam int TICK_FINE_CYC = STEP_FINE_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int DIV_COARSE = STEP_COARSE_MS / STEP_FINE_MS;
    localparam int DIV_HALF = STEP_HALF_S_MS / STEP_FINE_MS;
    localparam int DIV_LONG = STEP_LONG_MS / STEP_FINE_MS;
    // long scale step counted in half-second units
    localparam int LONG_PER_HALF = STEP_LONG_MS / STEP_HALF_S_MS;

    // ------------------------------------------------------------
    // delay line low pulse, square wave duty
    // ------------------------------------------------------------
    localparam logic [1:0] LN_PULSE_TICKS = 2'h2;
    localparam int PCT_FULL = 100;
    localparam logic [6:0] DUTY_DEF = 7'h32;
    localparam logic [6:0] DUTY_10 = 7'h0A;
    localparam logic [6:0] DUTY_20 = 7'h14;
    localparam logic [6:0] DUTY_30 = 7'h1E;
    localparam logic [6:0] DUTY_40 = 7'h28;
    localparam logic [6:0] DUTY_60 = 7'h3C;
    localparam logic [6:0] DUTY_70 = 7'h46;
    localparam logic [6:0] DUTY_80 = 7'h50;
    localparam logic [6:0] DUTY_90 = 7'h5A;
    localparam logic [6:0] SEL_10_80 = 7'h41;

endpackage

// *** step_tick_gen.sv ***
// Purpose: one-cycle enables at 10 ms, 100 ms, 0.5 s and 5 s
// Assumes: single clock ref_clk, async active-low reset
// Notes: all slower bases derive from the 10 ms enable
`timescale 1ns/1ps
module step_tick_gen
    import timer_ops_pkg::*;
#(
    parameter int CYC_FINE = TICK_FINE_CYC
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    output logic t_fine,
    output logic t_coarse,
    output logic t_half,
    output logic t_long
);

    typedef struct packed {
        logic [CYC_W-1:0] cyc;
        logic [3:0] c_coarse;
        logic [5:0] c_half;
        logic [8:0] c_long;
        logic t_fine;
        logic t_coarse;
        logic t_half;
        logic t_long;
    } tick_st_t;

    tick_st_t s_r;
    tick_st_t s_nxt;

    // ------------------------------------------------------------
    // dividers
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.t_fine = 1'b0;
        s_nxt.t_coarse = 1'b0;
        s_nxt.t_half = 1'b0;
        s_nxt.t_long = 1'b0;
        if (s_r.cyc == CYC_W'(CYC_FINE - 1)) begin
            s_nxt.cyc = '0;
            s_nxt.t_fine = 1'b1;
            s_nxt.c_coarse = 4'(s_r.c_coarse + 4'h1);
            s_nxt.c_half = 6'(s_r.c_half + 6'h1);
            s_nxt.c_long = 9'(s_r.c_long + 9'h1);
            if (s_r.c_coarse == 4'(DIV_COARSE - 1)) begin
                s_nxt.c_coarse = '0;
                s_nxt.t_coarse = 1'b1;
            end
            if (s_r.c_half == 6'(DIV_HALF - 1)) begin
                s_nxt.c_half = '0;
                s_nxt.t_half = 1'b1;
            end
            if (s_r.c_long == 9'(DIV_LONG - 1)) begin
                s_nxt.c_long = '0;
                s_nxt.t_long = 1'b1;
            end
        end else begin
            s_nxt.cyc = CYC_W'(s_r.cyc + 1'b1);
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign t_fine = s_r.t_fine;
    assign t_coarse = s_r.t_coarse;
    assign t_half = s_r.t_half;
    assign t_long = s_r.t_long;

endmodule // step_tick_gen

// *** safety_timer_operator_set.sv ***
// Purpose: timer operators of the safety logic program
// Assumes: inputs synchronous to ref_clk; one ref_clk = one system cycle
// Notes: index 0 of paired ports is short base, index 1 long base
`timescale 1ns/1ps
module safety_timer_operator_set
    import timer_ops_pkg::*;
#(
    parameter int CYC_FINE = TICK_FINE_CYC
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic cp_in,
    input wire logic cp_rise_sel,
    input wire logic cp_retrig,
    input wire logic cp_scale,
    input wire logic [TIME_W-1:0] cp_time,
    output logic cp_out,
    input wire logic pc_in,
    input wire logic pc_retrig,
    input wire logic pc_scale,
    input wire logic [TIME_W-1:0] pc_time,
    output logic pc_out,
    input wire logic [1:0] dl_in,
    input wire logic [1:0] dl_rise_sel,
    input wire logic [1:0] dl_retrig,
    input wire logic [1:0] dl_scale,
    input wire logic [1:0][TIME_W-1:0] dl_time,
    output logic [1:0] dl_out,
    input wire logic tv_en,
    output logic [TV_W-1:0] timer_value,
    input wire logic [TV_W-1:0] cmp_value,
    input wire logic cmp_scale,
    input wire logic [TIME_W-1:0] cmp_thresh,
    output logic cmp_out,
    input wire logic [1:0] ln_in,
    input wire logic [1:0] ln_scale,
    input wire logic [1:0][TIME_W-1:0] ln_time,
    output logic [1:0] ln_out,
    input wire logic sq_en,
    input wire logic [6:0] sq_duty_sel,
    input wire logic sq_scale,
    input wire logic [TIME_W-1:0] sq_time,
    output logic sq_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic cp_in_d;
        logic cp_act;
        logic [TIME_W-1:0] cp_cnt;
        logic cp_out;
        logic pc_in_d;
        logic pc_run;
        logic [TIME_W-1:0] pc_cnt;
        logic pc_out;
        logic [1:0] dl_in_d;
        logic [1:0] dl_run;
        logic [1:0][TIME_W-1:0] dl_cnt;
        logic [1:0] dl_out;
        logic [TV_W-1:0] tv_cnt;
        logic [TV_W-1:0] tv_out;
        logic cmp_out;
        logic [1:0] ln_in_d;
        logic [1:0] ln_run;
        logic [1:0] ln_pend;
        logic [1:0][TIME_W-1:0] ln_cnt;
        logic [1:0][1:0] ln_pulse;
        logic [1:0] ln_out;
        logic [TIME_W-1:0] sq_cnt;
        logic sq_out;
    } ops_st_t;

    ops_st_t s_r;
    ops_st_t s_nxt;
    logic t_fine;
    logic t_coarse;
    logic t_half;
    logic t_long;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic pick(input logic scale, input logic fine,
                                  input logic coarse);
        pick = scale ? coarse : fine;
    endfunction

    function automatic logic [TIME_W-1:0] bump(input logic [TIME_W-1:0] c,
                                               input logic tk);
        bump = (tk && (c != '1)) ? TIME_W'(c + 1'b1) : c;
    endfunction

    function automatic logic done(input logic [TIME_W-1:0] c,
                                  input logic [TIME_W-1:0] t);
        done = (c >= t);
    endfunction

    function automatic logic [6:0] duty_of(input logic [6:0] sel);
        case (sel)
            7'h01: duty_of = DUTY_10;
            7'h02: duty_of = DUTY_20;
            7'h04: duty_of = DUTY_30;
            7'h08: duty_of = DUTY_40;
            7'h10: duty_of = DUTY_60;
            7'h20: duty_of = DUTY_70;
            7'h40: duty_of = DUTY_80;
            SEL_10_80: duty_of = DUTY_90;
            // other mixes are the driver's fault; fall back to half
            default: duty_of = DUTY_DEF;
        endcase
    endfunction

    step_tick_gen #(
        .CYC_FINE(CYC_FINE)
    ) u_tick (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .t_fine(t_fine),
        .t_coarse(t_coarse),
        .t_half(t_half),
        .t_long(t_long)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic rise;
        logic fall;
        logic tk;
        logic st;
        logic [TV_W-1:0] thr;
        logic [DUTY_W-1:0] lhs;
        logic [DUTY_W-1:0] rhs;
        rise = 1'b0;
        fall = 1'b0;
        tk = 1'b0;
        st = 1'b0;
        thr = '0;
        lhs = '0;
        rhs = '0;
        s_nxt = s_r;

        // capped pulse
        rise = cp_in & ~s_r.cp_in_d;
        fall = ~cp_in & s_r.cp_in_d;
        tk = pick(cp_scale, t_fine, t_coarse);
        s_nxt.cp_in_d = cp_in;
        if ((cp_rise_sel ? rise : fall) && !s_r.cp_act) begin
            s_nxt.cp_act = 1'b1;
            s_nxt.cp_cnt = '0;
        end else if (s_r.cp_act && cp_retrig && (rise || fall)) begin
            s_nxt.cp_cnt = '0;
        end else if (s_r.cp_act) begin
            // input level is ignored here so the pulse cannot stretch
            if (done(s_r.cp_cnt, cp_time)) begin
                s_nxt.cp_act = 1'b0;
            end else begin
                s_nxt.cp_cnt = bump(s_r.cp_cnt, tk);
            end
        end
        s_nxt.cp_out = cp_rise_sel ? s_nxt.cp_act : ~s_nxt.cp_act;

        // passing contact
        rise = pc_in & ~s_r.pc_in_d;
        fall = ~pc_in & s_r.pc_in_d;
        tk = pick(pc_scale, t_fine, t_coarse);
        s_nxt.pc_in_d = pc_in;
        if (rise) begin
            s_nxt.pc_run = 1'b1;
            s_nxt.pc_cnt = '0;
        end else if (fall && !pc_retrig) begin
            s_nxt.pc_run = 1'b0;
            s_nxt.pc_cnt = '0;
        end else if (s_r.pc_run) begin
            if (done(s_r.pc_cnt, pc_time)) begin
                s_nxt.pc_run = 1'b0;
            end else begin
                s_nxt.pc_cnt = bump(s_r.pc_cnt, tk);
            end
        end
        s_nxt.pc_out = pc_retrig ? s_nxt.pc_run : (pc_in & s_nxt.pc_run);

        // delay, short and long
        for (int i = 0; i < 2; i++) begin
            rise = dl_in[i] & ~s_r.dl_in_d[i];
            fall = ~dl_in[i] & s_r.dl_in_d[i];
            tk = (i == 0) ? pick(dl_scale[i], t_fine, t_coarse)
                          : pick(dl_scale[i], t_half, t_long);
            st = 1'b0;
            s_nxt.dl_in_d[i] = dl_in[i];
            if (dl_rise_sel[i]) begin
                if (rise && (!s_r.dl_run[i] || dl_retrig[i])) begin
                    st = 1'b1;
                end
                if (fall && s_r.dl_run[i] && dl_retrig[i]) begin
                    st = 1'b1;
                end
                if (fall) begin
                    s_nxt.dl_out[i] = 1'b0;
                end
            end else begin
                if (rise) begin
                    s_nxt.dl_out[i] = 1'b1;
                    s_nxt.dl_run[i] = 1'b0;
                end
                if (fall && (!s_r.dl_run[i] || dl_retrig[i])) begin
                    st = 1'b1;
                end
            end
            if (st) begin
                s_nxt.dl_run[i] = 1'b1;
                s_nxt.dl_cnt[i] = '0;
            end else if (s_r.dl_run[i] && !(rise && !dl_rise_sel[i])) begin
                if (done(s_r.dl_cnt[i], dl_time[i])) begin
                    s_nxt.dl_run[i] = 1'b0;
                    if (dl_rise_sel[i]) begin
                        s_nxt.dl_out[i] = dl_in[i];
                    end else if (!dl_in[i]) begin
                        s_nxt.dl_out[i] = 1'b0;
                    end
                end else begin
                    s_nxt.dl_cnt[i] = bump(s_r.dl_cnt[i], tk);
                end
            end
            if (i == 1) begin
                // elapsed time kept in half-second units on both scales
                if (st) begin
                    s_nxt.tv_cnt = '0;
                end else if (s_r.dl_run[1] && t_half && (s_r.tv_cnt != '1)) begin
                    s_nxt.tv_cnt = TV_W'(s_r.tv_cnt + 1'b1);
                end
            end
        end
        s_nxt.tv_out = tv_en ? s_nxt.tv_cnt : '0;

        // threshold comparator; its value port comes from timer_value, or from a fixed value when the partner selects one
        thr = cmp_scale ? TV_W'(cmp_thresh * TV_W'(LONG_PER_HALF))
                        : TV_W'(cmp_thresh);
        s_nxt.cmp_out = (cmp_value >= thr);

        // delay lines, short and long
        for (int i = 0; i < 2; i++) begin
            rise = ln_in[i] & ~s_r.ln_in_d[i];
            fall = ~ln_in[i] & s_r.ln_in_d[i];
            tk = (i == 0) ? pick(ln_scale[i], t_fine, t_coarse)
                          : pick(ln_scale[i], t_half, t_long);
            s_nxt.ln_in_d[i] = ln_in[i];
            // a second fall while timing is not queued: one timer only
            if (fall && !s_r.ln_run[i]) begin
                s_nxt.ln_run[i] = 1'b1;
                s_nxt.ln_cnt[i] = '0;
                s_nxt.ln_pend[i] = 1'b0;
            end else if (s_r.ln_run[i]) begin
                if (rise) begin
                    s_nxt.ln_pend[i] = 1'b1;
                end
                if (done(s_r.ln_cnt[i], ln_time[i])) begin
                    s_nxt.ln_run[i] = 1'b0;
                    s_nxt.ln_out[i] = 1'b0;
                    if (s_r.ln_pend[i] || ln_in[i]) begin
                        s_nxt.ln_pulse[i] = LN_PULSE_TICKS;
                    end
                end else begin
                    s_nxt.ln_cnt[i] = bump(s_r.ln_cnt[i], tk);
                end
            end
            if (s_r.ln_pulse[i] != 2'h0 && t_fine) begin
                s_nxt.ln_pulse[i] = 2'(s_r.ln_pulse[i] - 2'h1);
            end
            if (!s_nxt.ln_run[i] && s_nxt.ln_pulse[i] == 2'h0
                    && !(fall && !s_r.ln_run[i])) begin
                s_nxt.ln_out[i] = ln_in[i];
            end
        end

        // square wave
        tk = pick(sq_scale, t_fine, t_coarse);
        if (!sq_en) begin
            s_nxt.sq_cnt = '0;
            s_nxt.sq_out = 1'b0;
        end else begin
            if (tk) begin
                if (TIME_W'(s_r.sq_cnt + 1'b1) >= sq_time) begin
                    s_nxt.sq_cnt = '0;
                end else begin
                    s_nxt.sq_cnt = TIME_W'(s_r.sq_cnt + 1'b1);
                end
            end
            lhs = DUTY_W'(s_nxt.sq_cnt) * DUTY_W'(PCT_FULL);
            rhs = DUTY_W'(sq_time) * DUTY_W'(duty_of(sq_duty_sel));
            s_nxt.sq_out = (lhs < rhs);
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cp_out = s_r.cp_out;
    assign pc_out = s_r.pc_out;
    assign dl_out = s_r.dl_out;
    assign timer_value = s_r.tv_out;
    assign cmp_out = s_r.cmp_out;
    assign ln_out = s_r.ln_out;
    assign sq_out = s_r.sq_out;

endmodule // safety_timer_operator_set

// *** timer_ops_asserts.sv ***
// Purpose: port-level assertions on the timer operator set
// Assumes: single clock ref_clk, async active-low reset
// Notes: pulse bound allows a partial first step plus clocks
`timescale 1ns/1ps
module timer_ops_asserts
    import timer_ops_pkg::*;
#(
    parameter int CYC_FINE = TICK_FINE_CYC
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic cp_rise_sel,
    input wire logic cp_retrig,
    input wire logic cp_scale,
    input wire logic [TIME_W-1:0] cp_time,
    input wire logic cp_out,
    input wire logic pc_in,
    input wire logic pc_retrig,
    input wire logic pc_out,
    input wire logic [1:0] dl_in,
    input wire logic [1:0] dl_rise_sel,
    input wire logic [1:0] dl_out,
    input wire logic tv_en,
    input wire logic [TV_W-1:0] timer_value,
    input wire logic [TV_W-1:0] cmp_value,
    input wire logic cmp_scale,
    input wire logic [TIME_W-1:0] cmp_thresh,
    input wire logic cmp_out,
    input wire logic sq_en,
    input wire logic sq_out
);
    logic [31:0] act_cnt_r;
    logic [31:0] act_lim;
    logic cmp_ge;
    // retrigger may stretch the pulse, so only counted without it
    assign act_lim = (32'(cp_time) + 32'h1) * 32'(CYC_FINE)
        * (cp_scale ? 32'(DIV_COARSE) : 32'h1) + 32'h3;
    assign cmp_ge = {4'h0, cmp_value} >= (cmp_scale ? 21'(cmp_thresh) * 21'(LONG_PER_HALF)
        : 21'(cmp_thresh));
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            act_cnt_r <= 32'h0;
        end else if ((cp_out == cp_rise_sel) && !cp_retrig) begin
            act_cnt_r <= act_cnt_r + 32'h1;
        end else begin
            act_cnt_r <= 32'h0;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    property p_cp_bound; act_cnt_r <= act_lim; endproperty
    a_cp_bound: assert property (p_cp_bound) else $error("pulse too long");
    property p_cmp; 1'b1 |=> cmp_out == $past(cmp_ge); endproperty
    a_cmp: assert property (p_cmp) else $error("cmp_out wrong");
    property p_sq_off; !sq_en |=> !sq_out; endproperty
    a_sq_off: assert property (p_sq_off) else $error("sq_out while off");
    property p_dl_rise; $rose(dl_out[0]) |-> $past(dl_in[0]); endproperty
    a_dl_rise: assert property (p_dl_rise) else $error("dl_out rose, input 0");
    property p_dl_low; dl_rise_sel[0] && !dl_in[0] |=> !dl_out[0]; endproperty
    a_dl_low: assert property (p_dl_low) else $error("dl_out high, input 0");
    property p_dl_inv; !dl_rise_sel[0] && dl_in[0] |=> dl_out[0]; endproperty
    a_dl_inv: assert property (p_dl_inv) else $error("dl_out low, input 1");
    property p_pc_low; !pc_retrig && !pc_in |=> !pc_out; endproperty
    a_pc_low: assert property (p_pc_low) else $error("pc_out high, input 0");
    property p_tv_off; !tv_en |=> timer_value == '0; endproperty
    a_tv_off: assert property (p_tv_off) else $error("timer_value while off");
    c_cp: cover property (act_cnt_r == 32'h8);
    c_cmp: cover property ($rose(cmp_out));
    c_sq: cover property ($rose(sq_out));
endmodule // timer_ops_asserts

bind safety_timer_operator_set timer_ops_asserts #(.CYC_FINE(CYC_FINE)) CHK (
    .ref_clk(ref_clk), .arst_n(arst_n), .cp_rise_sel(cp_rise_sel), .cp_retrig(cp_retrig),
    .cp_scale(cp_scale), .cp_time(cp_time), .cp_out(cp_out), .pc_in(pc_in),
    .pc_retrig(pc_retrig), .pc_out(pc_out), .dl_in(dl_in), .dl_rise_sel(dl_rise_sel),
    .dl_out(dl_out), .tv_en(tv_en), .timer_value(timer_value), .cmp_value(cmp_value),
    .cmp_scale(cmp_scale), .cmp_thresh(cmp_thresh), .cmp_out(cmp_out), .sq_en(sq_en),
    .sq_out(sq_out));

// *** logic_ops_partner.sv ***
// Purpose: neighbouring logic operators of the timer set
// Assumes: combinational, same system cycle
// Notes: fixed value stands in for a second long delay timer
`timescale 1ns/1ps
module logic_ops_partner
    import timer_ops_pkg::*;
(
    input wire logic [TV_W-1:0] timer_value,
    input wire logic fix_en,
    input wire logic [TV_W-1:0] fix_value,
    input wire logic [3:0] duty_code,
    output logic [TV_W-1:0] cmp_value,
    output logic [6:0] sq_duty_sel
);
    assign cmp_value = fix_en ? fix_value : timer_value;
    // never more than one selection, 10 plus 80 the only pair
    always_comb begin
        case (duty_code)
            4'h0: sq_duty_sel = 7'h00;
            4'h8: sq_duty_sel = SEL_10_80;
            default: sq_duty_sel = 7'h01 << (duty_code - 4'h1);
        endcase
    end
endmodule // logic_ops_partner

// *** safety_timer_operator_set_test.sv ***
// Purpose: self-checking bench for the timer operator set
// Assumes: CYC_FINE cut to 4 clocks per 10 ms step
// Notes: inputs change at the falling edge; durations in clocks
`timescale 1ns/1ps
module safety_timer_operator_set_test
    import timer_ops_pkg::*;
;
    localparam int CF = 4;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic cp_in = 1'b0, cp_rise_sel = 1'b1, cp_retrig = 1'b0, cp_scale = 1'b0;
    logic pc_in = 1'b0, pc_retrig = 1'b0, pc_scale = 1'b0, tv_en = 1'b0;
    logic cmp_scale = 1'b0, sq_en = 1'b0, sq_scale = 1'b0, fix_en = 1'b0;
    logic cp_out, pc_out, cmp_out, sq_out;
    logic [1:0] dl_in = 2'h0, dl_rise_sel = 2'h3, dl_retrig = 2'h0, dl_scale = 2'h0;
    logic [1:0] ln_in = 2'h3, ln_scale = 2'h0, dl_out, ln_out;
    logic [TIME_W-1:0] cp_time = 14'h3, pc_time = 14'h3, cmp_thresh = 14'h2, sq_time = 14'hA;
    logic [1:0][TIME_W-1:0] dl_time = {14'h2, 14'h3}, ln_time = {14'h3, 14'h3};
    logic [TV_W-1:0] timer_value, cmp_value, fix_value = 17'h0;
    logic [6:0] sq_duty_sel;
    logic [3:0] duty_code = 4'h0;
    int error_cnt = 0;
    int n_tests = 0;
    safety_timer_operator_set #(.CYC_FINE(CF)) DUT (
        .ref_clk(ref_clk), .arst_n(arst_n), .cp_in(cp_in), .cp_rise_sel(cp_rise_sel),
        .cp_retrig(cp_retrig), .cp_scale(cp_scale), .cp_time(cp_time), .cp_out(cp_out),
        .pc_in(pc_in), .pc_retrig(pc_retrig), .pc_scale(pc_scale), .pc_time(pc_time),
        .pc_out(pc_out), .dl_in(dl_in), .dl_rise_sel(dl_rise_sel), .dl_retrig(dl_retrig),
        .dl_scale(dl_scale), .dl_time(dl_time), .dl_out(dl_out), .tv_en(tv_en),
        .timer_value(timer_value), .cmp_value(cmp_value), .cmp_scale(cmp_scale),
        .cmp_thresh(cmp_thresh), .cmp_out(cmp_out), .ln_in(ln_in), .ln_scale(ln_scale),
        .ln_time(ln_time), .ln_out(ln_out), .sq_en(sq_en), .sq_duty_sel(sq_duty_sel),
        .sq_scale(sq_scale), .sq_time(sq_time), .sq_out(sq_out));
    logic_ops_partner PEER (.timer_value(timer_value), .fix_en(fix_en),
        .fix_value(fix_value), .duty_code(duty_code), .cmp_value(cmp_value),
        .sq_duty_sel(sq_duty_sel));
    function automatic logic exp_ge(input logic [16:0] v, input logic [13:0] t, input logic s);
        return {4'h0, v} >= (s ? 21'(t) * 21'hA : 21'(t));
    endfunction
    function automatic int exp_duty(input int c);
        int dt[9] = '{50, 10, 20, 30, 40, 60, 70, 80, 90};
        return dt[c];
    endfunction
    function automatic logic pick(input int w);
        case (w)
            0: return cp_out;
            1: return pc_out;
            2: return dl_out[0];
            3: return dl_out[1];
            4: return ln_out[0];
            5: return ln_out[1];
            default: return sq_out;
        endcase
    endfunction
    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        n_tests++;
        if (g < lo || g > hi) begin
            error_cnt++;
            $display("ERROR %s expected %0d to %0d seen %0d", nm, lo, hi, g);
        end
    endtask
    // first step may be partial, so one step of slack below
    task automatic chk_dur(input string nm, input int t, input int st, input int g);
        chk_rng(nm, (t - 1) * st, t * st + 3, g);
    endtask
    task automatic dur(input int w, input logic lvl, input int mx, output int n);
        n = 0;
        while (pick(w) === lvl && n < mx) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        #(40 * 20000);
        error_cnt++;
        finish_test();
    end
    initial begin
        int n;
        void'($urandom(76880));
        @(negedge ref_clk);
        chk_val("reset", 32'h0, {cp_out, pc_out, dl_out, ln_out, sq_out, timer_value});
        @(negedge ref_clk);
        arst_n = 1'b1;
        for (int i = 0; i < 2; i++) begin
            cp_scale = i[0];
            cp_in = 1'b0;
            repeat (6) @(negedge ref_clk);
            cp_in = 1'b1;
            dur(0, 1'b0, 5, n);
            // second edge while active must not restart the pulse
            repeat (6) @(negedge ref_clk);
            cp_in = 1'b0;
            @(negedge ref_clk);
            cp_in = 1'b1;
            dur(0, 1'b1, 200, n);
            chk_dur("cp high", 3, i ? 10 * CF : CF, n + 7);
            repeat (8) @(negedge ref_clk);
            chk_val("cp held", 32'h0, cp_out);
        end
        cp_scale = 1'b0;
        cp_rise_sel = 1'b0;
        cp_in = 1'b1;
        repeat (6) @(negedge ref_clk);
        cp_in = 1'b0;
        dur(0, 1'b1, 5, n);
        dur(0, 1'b0, 200, n);
        chk_dur("cp low", 3, CF, n);
        cp_time = 14'h4;
        cp_retrig = 1'b1;
        cp_in = 1'b1;
        repeat (6) @(negedge ref_clk);
        cp_in = 1'b0;
        repeat (10) @(negedge ref_clk);
        cp_in = 1'b1;
        @(negedge ref_clk);
        cp_in = 1'b0;
        dur(0, 1'b0, 200, n);
        chk_dur("cp retrig", 4, CF, n);
        cp_retrig = 1'b0;
        for (int r = 0; r < 2; r++) begin
            pc_retrig = r[0];
            pc_scale = r[0];
            pc_in = 1'b1;
            @(negedge ref_clk);
            pc_in = ~r[0];
            dur(1, 1'b1, 200, n);
            chk_dur("pc high", 3, r ? 10 * CF : CF, n);
            repeat (4) @(negedge ref_clk);
            chk_val("pc drop", 32'h0, pc_out);
            pc_in = 1'b0;
            repeat (4) @(negedge ref_clk);
        end
        dl_in[0] = 1'b1;
        dur(2, 1'b0, 200, n);
        chk_dur("dl on", 3, CF, n);
        dl_rise_sel[0] = 1'b0;
        dl_in[0] = 1'b0;
        repeat (20) @(negedge ref_clk);
        dl_in[0] = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk_val("dl inv", 32'h1, dl_out[0]);
        dl_scale[0] = 1'b1;
        dl_in[0] = 1'b0;
        dur(2, 1'b1, 200, n);
        chk_dur("dl inv hold", 3, 10 * CF, n);
        tv_en = 1'b1;
        dl_in[1] = 1'b1;
        dur(3, 1'b0, 1000, n);
        chk_dur("long on", 2, 50 * CF, n);
        repeat (2) @(negedge ref_clk);
        chk_val("tv", 32'h2, timer_value);
        chk_val("cmp tv", 32'h1, cmp_out);
        tv_en = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk_val("tv off", 32'h0, timer_value);
        fix_en = 1'b1;
        for (int i = 0; i < 24; i++) begin
            cmp_scale = 1'($urandom_range(1, 0));
            cmp_thresh = 14'($urandom_range(13000, 1));
            fix_value = i < 8 ? 17'((cmp_scale ? cmp_thresh * 10 : cmp_thresh) - i % 2)
                : 17'($urandom_range(131071, 0));
            repeat (2) @(negedge ref_clk);
            chk_val("cmp", exp_ge(fix_value, cmp_thresh, cmp_scale), cmp_out);
        end
        fix_en = 1'b0;
        ln_in[0] = 1'b0;
        dur(4, 1'b1, 200, n);
        chk_dur("ln fall", 3, CF, n);
        repeat (4) @(negedge ref_clk);
        chk_val("ln low", 32'h0, ln_out[0]);
        ln_in[0] = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk_val("ln rise", 32'h1, ln_out[0]);
        ln_in[0] = 1'b0;
        @(negedge ref_clk);
        ln_in[0] = 1'b1;
        dur(4, 1'b1, 200, n);
        chk_dur("ln late", 3, CF, n);
        dur(4, 1'b0, 100, n);
        chk_rng("ln pulse", CF, 2 * CF + 3, n);
        ln_in[1] = 1'b0;
        dur(5, 1'b1, 1000, n);
        chk_dur("ln long", 3, 50 * CF, n);
        for (int c = 0; c < 9; c++) begin
            duty_code = 4'(c);
            sq_scale = c[0];
            sq_en = 1'b1;
            repeat (45) @(negedge ref_clk);
            n = 0;
            repeat (400) begin
                @(negedge ref_clk);
                n += (sq_out === 1'b1) ? 1 : 0;
            end
            chk_rng("sq duty", exp_duty(c) * 4 - 6, exp_duty(c) * 4 + 6, n);
            sq_en = 1'b0;
            repeat (2) @(negedge ref_clk);
            chk_val("sq off", 32'h0, sq_out);
        end
        finish_test();
    end
endmodule // safety_timer_operator_set_test
